// [rtl/pwm_timer_regs.svh]
// Register offsets, field positions and reset values of the two-channel PWM timer.
// Included by every file that decodes these registers.
`ifndef PWM_TIMER_REGS_SVH
`define PWM_TIMER_REGS_SVH

// Register byte offsets on the plain register port.
`define OFS_RUN_CTRL 8'h00
`define OFS_FUNC_CTRL 8'h04
`define OFS_BUF_MODE 8'h08
`define OFS_CHAN_CTRL 8'h0C
`define OFS_PERIOD 8'h10
`define OFS_GEN_U 8'h14
`define OFS_GEN_V 8'h18
`define OFS_GEN_W 8'h1C
`define OFS_BUF_U 8'h20
`define OFS_BUF_V 8'h24
`define OFS_BUF_W 8'h28
`define OFS_CNT0 8'h2C
`define OFS_CNT1 8'h30
`define OFS_STATUS 8'h34
`define OFS_IRQ_MASK 8'h38
`define OFS_CAPTURE 8'h3C

// Run control fields.
`define BIT_CH0_RUN 0
`define BIT_CH1_RUN 1
`define BIT_CH1_STOP_SEL 2
// Function control fields.
`define FLD_CMODE_LO 0
`define BIT_POS_LEVEL 2
`define BIT_NEG_LEVEL 3
// Status and mask fields.
`define BIT_MATCH_A 0
`define BIT_UNDERFLOW 1
`define BIT_OVERFLOW 2
`define BIT_CAPTURE 3

// Reset values, counter landmarks and the highest divider selection.
`define RST_PERIOD 16'hFFFF
`define RST_ZERO16 16'h0000
`define CNT_ONE 16'h0001
`define CNT_ALL_ONES 16'hFFFF
`define DIV_SEL_MAX 3'h3

`endif

// [rtl/pwm_timer_pkg.sv]
// Types shared by the PWM timer modules.
// Constants live in pwm_timer_regs.svh; this package holds only types.
package pwm_timer_pkg;

    // Combination mode field encodings.
    typedef enum logic [1:0] {
        CMODE_TIMER = 2'b00,
        CMODE_RESET_SYNC = 2'b01,
        CMODE_COMP_UDF = 2'b10,
        CMODE_COMP_CREST = 2'b11
    } cmode_t;

    // Timing that a duty buffer transfer currently obeys.
    typedef enum logic [1:0] {
        XFER_SELECTED = 2'b00,
        XFER_AT_UNDERFLOW = 2'b01,
        XFER_AT_CREST = 2'b10
    } xfer_kind_t;

endpackage

// [rtl/capture_sync.sv]
// Capture pin synchroniser with rising edge detection.
// Assumes an asynchronous pin; emits a one-cycle strobe in the clock_in domain.
`timescale 1ns/10ps
`default_nettype none

module capture_sync (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic pin_in,
    output logic edge_out
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } cap_state_t;

    cap_state_t s_q;
    cap_state_t s_d;

    // The first stage feeds only the second stage; edges are taken after it.
    always_comb begin
        s_d = s_q;
        s_d.meta = pin_in;
        s_d.sync = s_q.meta;
        s_d.prev = s_q.sync;
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Decoded straight from the flops: a registered strobe would add a cycle and
    // push the capture past its three-clock latency limit.
    assign edge_out = s_q.sync & ~s_q.prev;

endmodule
`default_nettype wire

// [rtl/duty_transfer.sv]
// One duty phase: its buffer-to-general transfer timing and its general register.
// Assumes crest and trough strobes are one cycle wide and come from the counters.
`timescale 1ns/10ps
`default_nettype none

module duty_transfer
    import pwm_timer_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] buf_in,
    input wire logic buf_wr_in,
    input wire logic [WIDTH-1:0] period_in,
    input wire logic buf_mode_in,
    input wire pwm_timer_pkg::cmode_t cmode_in,
    input wire logic crest_in,
    input wire logic trough_in,
    input wire logic gen_wr_in,
    input wire logic [WIDTH-1:0] gen_wdata_in,
    output logic [WIDTH-1:0] gen_out
);
    typedef struct packed {
        xfer_kind_t kind;
        logic wr_seen;
        logic [WIDTH-1:0] gen;
    } duty_state_t;

    duty_state_t s_q;
    duty_state_t s_d;
    xfer_kind_t buf_kind;
    xfer_kind_t eff_kind;
    logic sel_hit;
    logic do_xfer;

    // Classify the buffer value by the special timings it forces.
    always_comb begin
        if (buf_in >= period_in) begin
            buf_kind = XFER_AT_UNDERFLOW;
        end else if (buf_in == '0) begin
            buf_kind = XFER_AT_CREST;
        end else begin
            buf_kind = XFER_SELECTED;
        end
    end

    assign sel_hit = (cmode_in == CMODE_COMP_CREST && crest_in) ||
                     (cmode_in == CMODE_COMP_UDF && trough_in);

    // override to underflow; override to crest match.
    // A special value forces its own timing; a normal one inherits the last special once.
    assign eff_kind = (buf_kind != XFER_SELECTED) ? buf_kind : s_q.kind;
    always_comb begin
        unique case (eff_kind)
            XFER_AT_UNDERFLOW: do_xfer = trough_in;
            XFER_AT_CREST: do_xfer = crest_in;
            XFER_SELECTED: do_xfer = sel_hit;
            default: do_xfer = sel_hit;
        endcase
    end

    // A new normal value keeps the old timing for its first transfer, then reverts.
    always_comb begin
        s_d = s_q;
        s_d.wr_seen = buf_wr_in;
        if (buf_mode_in && cmode_in[1] && do_xfer) begin
            s_d.gen = buf_in;
            s_d.kind = buf_kind;
        end else if (gen_wr_in) begin
            s_d.gen = gen_wdata_in;
        end
        // The buffer register changes at the strobe edge, so classify one cycle later.
        if (s_q.wr_seen && buf_kind != XFER_SELECTED) begin
            s_d.kind = buf_kind;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '{kind: XFER_SELECTED, wr_seen: 1'b0, gen: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign gen_out = s_q.gen;

endmodule
`default_nettype wire

// [rtl/pwm_timer_top.sv]
// Two-channel 16-bit timer with reset-synchronous and complementary PWM.
// Assumes a plain register port on clock_in and an asynchronous capture pin.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_timer_regs.svh"

module pwm_timer_top
    import pwm_timer_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int PHASES = 3
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic capture_pin_in,
    output logic [15:0] rdata_out,
    output logic irq_out,
    output logic [PHASES-1:0] pos_phase_out,
    output logic [PHASES-1:0] neg_phase_out
);
    typedef struct packed {
        logic ch0_run;
        logic ch1_run;
        logic ch1_stop_select;
        cmode_t cmode;
        logic pos_level;
        logic neg_level;
        logic [PHASES-1:0] buf_mode;
        logic [2:0] src_sel;
        logic [2:0] prescale;
        logic [WIDTH-1:0] period;
        logic [PHASES-1:0][WIDTH-1:0] dbuf;
        logic [WIDTH-1:0] cnt0;
        logic [WIDTH-1:0] cnt1;
        logic cnt0_down;
        logic cnt1_down;
        logic [3:0] status;
        logic [3:0] mask;
        logic [WIDTH-1:0] capt;
        logic [15:0] rdata;
        logic irq;
        logic [PHASES-1:0] pos;
        logic [PHASES-1:0] neg;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;

    logic [PHASES-1:0][WIDTH-1:0] gen;
    logic [PHASES-1:0] buf_wr;
    logic [PHASES-1:0] gen_wr;
    logic cap_edge;
    logic tick;
    logic [2:0] div_mask;
    logic comp_mode;
    logic crest;
    logic trough;
    logic [3:0] set_flags;
    logic [15:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////////
    // Capture pin path and per-phase transfer logic.

    // capture latency: two sync stages, then the edge decode.
    capture_sync i_capture_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .pin_in(capture_pin_in),
        .edge_out(cap_edge)
    );

    // Buffer and general registers are at consecutive word offsets per phase.
    genvar p;
    generate
        for (p = 0; p < PHASES; p++) begin : g_phase
            assign buf_wr[p] = wr_in && addr_in == `OFS_BUF_U + 8'(4 * p);
            assign gen_wr[p] = wr_in && addr_in == `OFS_GEN_U + 8'(4 * p);
            duty_transfer #(
                .WIDTH(WIDTH)
            ) i_duty_transfer (
                .clock_in(clock_in),
                .rst_n_in(rst_n_in),
                .buf_in(s_q.dbuf[p]),
                .buf_wr_in(s_q.buf_mode[p] ? 1'b0 : buf_wr[p]),
                .period_in(s_q.period),
                .buf_mode_in(s_q.buf_mode[p]),
                .cmode_in(s_q.cmode),
                .crest_in(crest),
                .trough_in(trough),
                .gen_wr_in(gen_wr[p]),
                .gen_wdata_in(wdata_in[WIDTH-1:0]),
                .gen_out(gen[p])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Count source divider and counter landmarks.

    // Selections above the divider range count on every clock.
    always_comb begin
        if (s_q.src_sel > `DIV_SEL_MAX) begin
            div_mask = 3'h0;
        end else begin
            div_mask = 3'((4'h1 << s_q.src_sel) - 4'h1);
        end
    end

    assign tick = (s_q.prescale & div_mask) == div_mask;
    assign comp_mode = s_q.cmode[1];

    // crest step from period to period plus one.
    assign crest = comp_mode && s_q.ch0_run && tick && !s_q.cnt0_down &&
                   s_q.cnt0 == s_q.period;
    // trough step from zero to all ones.
    assign trough = comp_mode && s_q.ch0_run && tick && s_q.cnt1_down &&
                    s_q.cnt1 == `RST_ZERO16;

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; the result is registered for the next cycle.

    always_comb begin
        rd_mux = '0;
        unique case (addr_in)
            `OFS_RUN_CTRL: rd_mux = {13'h0000, s_q.ch1_stop_select, s_q.ch1_run, s_q.ch0_run};
            `OFS_FUNC_CTRL: rd_mux = {12'h0000, s_q.neg_level, s_q.pos_level, s_q.cmode};
            `OFS_BUF_MODE: rd_mux = 16'(s_q.buf_mode);
            `OFS_CHAN_CTRL: rd_mux = {13'h0000, s_q.src_sel};
            `OFS_PERIOD: rd_mux = s_q.period;
            `OFS_GEN_U: rd_mux = gen[0];
            `OFS_GEN_V: rd_mux = gen[1];
            `OFS_GEN_W: rd_mux = gen[2];
            `OFS_BUF_U: rd_mux = s_q.dbuf[0];
            `OFS_BUF_V: rd_mux = s_q.dbuf[1];
            `OFS_BUF_W: rd_mux = s_q.dbuf[2];
            `OFS_CNT0: rd_mux = s_q.cnt0;
            `OFS_CNT1: rd_mux = s_q.cnt1;
            `OFS_STATUS: rd_mux = {12'h000, s_q.status};
            `OFS_IRQ_MASK: rd_mux = {12'h000, s_q.mask};
            `OFS_CAPTURE: rd_mux = s_q.capt;
            default: rd_mux = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: registers, counters, flags and outputs.

    always_comb begin
        s_d = s_q;
        set_flags = '0;
        s_d.rdata = rd_in ? rd_mux : '0;
        s_d.prescale = s_q.prescale + 3'h1;

        // Control register writes; software keeps the stop-first sequences.
        if (wr_in) begin
            unique case (addr_in)
                `OFS_RUN_CTRL: begin
                    s_d.ch0_run = wdata_in[`BIT_CH0_RUN];
                    s_d.ch1_run = wdata_in[`BIT_CH1_RUN];
                    s_d.ch1_stop_select = wdata_in[`BIT_CH1_STOP_SEL];
                end
                `OFS_FUNC_CTRL: begin
                    s_d.cmode = cmode_t'(wdata_in[`FLD_CMODE_LO +: 2]);
                    s_d.pos_level = wdata_in[`BIT_POS_LEVEL];
                    s_d.neg_level = wdata_in[`BIT_NEG_LEVEL];
                end
                `OFS_BUF_MODE: s_d.buf_mode = wdata_in[PHASES-1:0];
                `OFS_CHAN_CTRL: s_d.src_sel = wdata_in[2:0];
                `OFS_PERIOD: s_d.period = wdata_in[WIDTH-1:0];
                `OFS_BUF_U: s_d.dbuf[0] = wdata_in[WIDTH-1:0];
                `OFS_BUF_V: s_d.dbuf[1] = wdata_in[WIDTH-1:0];
                `OFS_BUF_W: s_d.dbuf[2] = wdata_in[WIDTH-1:0];
                `OFS_CNT0: s_d.cnt0 = wdata_in[WIDTH-1:0];
                `OFS_CNT1: s_d.cnt1 = wdata_in[WIDTH-1:0];
                `OFS_IRQ_MASK: s_d.mask = wdata_in[3:0];
                default: ;
            endcase
        end

        if (comp_mode) begin
            // counter0 turns down after period plus one.
            if (s_q.ch0_run && tick) begin
                if (!s_q.cnt0_down) begin
                    s_d.cnt0 = s_q.cnt0 + `CNT_ONE;
                    if (s_q.cnt0 == s_q.period + `CNT_ONE) begin
                        s_d.cnt0 = s_q.cnt0 - `CNT_ONE;
                        s_d.cnt0_down = 1'b1;
                    end
                end else begin
                    s_d.cnt0 = s_q.cnt0 - `CNT_ONE;
                    if (s_q.cnt0 == `RST_ZERO16) begin
                        s_d.cnt0 = `CNT_ONE;
                        s_d.cnt0_down = 1'b0;
                    end
                end
                // counter1 counts 1, 0, all ones, 0, 1.
                if (s_q.cnt1_down) begin
                    s_d.cnt1 = s_q.cnt1 - `CNT_ONE;
                    if (s_q.cnt1 == `CNT_ALL_ONES) begin
                        s_d.cnt1 = `RST_ZERO16;
                        s_d.cnt1_down = 1'b0;
                    end
                end else begin
                    s_d.cnt1 = s_q.cnt1 + `CNT_ONE;
                    if (s_q.cnt1 == s_q.period) begin
                        s_d.cnt1 = s_q.cnt1 - `CNT_ONE;
                        s_d.cnt1_down = 1'b1;
                    end
                end
            end
            set_flags[`BIT_MATCH_A] = crest;
            set_flags[`BIT_UNDERFLOW] = trough;
        end else begin
            // Plain counting: counter0 clears on period match, counter1 counts and wraps in timer mode only.
            s_d.cnt0_down = 1'b0;
            s_d.cnt1_down = 1'b1;
            if (s_q.ch0_run && tick) begin
                s_d.cnt0 = s_q.cnt0 + `CNT_ONE;
                if (s_q.cnt0 == s_q.period) begin
                    s_d.cnt0 = `RST_ZERO16;
                    set_flags[`BIT_MATCH_A] = 1'b1;
                end
            end
            if (s_q.ch1_run && tick && s_q.cmode == CMODE_TIMER) begin
                s_d.cnt1 = s_q.cnt1 + `CNT_ONE;
                set_flags[`BIT_OVERFLOW] = s_q.cnt1 == `CNT_ALL_ONES;
            end
        end

        // counter0 copied into the capture register.
        if (cap_edge) begin
            s_d.capt = s_q.cnt0;
            set_flags[`BIT_CAPTURE] = 1'b1;
        end

        // Write one to clear; a flag set in the same cycle survives the clear.
        if (wr_in && addr_in == `OFS_STATUS) begin
            s_d.status = s_q.status & ~wdata_in[3:0];
        end
        s_d.status = s_d.status | set_flags;
        s_d.irq = |(s_d.status & s_d.mask);

        // Phase outputs: active level chosen by the level select bits.
        for (int i = 0; i < PHASES; i++) begin
            if (comp_mode) begin
                s_d.pos[i] = (gen[i] < s_q.cnt1) ^ ~s_q.pos_level;
                s_d.neg[i] = (gen[i] > s_q.cnt0) ^ ~s_q.neg_level;
            end else if (s_q.cmode == CMODE_RESET_SYNC) begin
                s_d.pos[i] = (s_q.cnt0 < gen[i]) ^ ~s_q.pos_level;
                s_d.neg[i] = (s_q.cnt0 >= gen[i]) ^ ~s_q.neg_level;
            end else begin
                s_d.pos[i] = ~s_q.pos_level;
                s_d.neg[i] = ~s_q.neg_level;
            end
        end
    end

    // All state resets to constants only.
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
            s_q.period <= `RST_PERIOD;
            s_q.cnt1_down <= 1'b1;
            s_q.pos <= '1;
            s_q.neg <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_out = s_q.rdata;
    assign irq_out = s_q.irq;
    assign pos_phase_out = s_q.pos;
    assign neg_phase_out = s_q.neg;

endmodule
`default_nettype wire

// [test/pwm_timer_monitor.sv]
// Concurrent checks of the PWM timer, seen only from its top-level ports.
// Assumes the offsets header is on the include path; the bind follows the module.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_timer_regs.svh"

module pwm_timer_monitor #(
    parameter int WIDTH = 16,
    parameter int PHASES = 3
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic capture_pin_in,
    input wire logic [15:0] rdata_out,
    input wire logic irq_out,
    input wire logic [PHASES-1:0] pos_phase_out,
    input wire logic [PHASES-1:0] neg_phase_out
);
    logic [3:0] mask_q;
    logic [15:0] per_q;
    logic [3:0] func_q;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    ////////////////////////////////////////////////////////////////////////////////
    // Shadows of software writes, so the checks know mask, period and mode.
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask_q <= 4'h0;
            per_q <= `RST_PERIOD;
            func_q <= 4'h0;
        end else if (wr_in) begin
            if (addr_in == `OFS_IRQ_MASK) mask_q <= wdata_in[3:0];
            if (addr_in == `OFS_PERIOD) per_q <= wdata_in;
            if (addr_in == `OFS_FUNC_CTRL) func_q <= wdata_in[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin to capture takes two or three clocks; the interrupt is sampled at the third edge.
    sequence cap_quiet;
        ##1 !irq_out [*2];
    endsequence
    sequence cap_lands;
        ##1 irq_out;
    endsequence

    read_idle_zero_a: assert property (!rd_in |=> rdata_out == 16'h0000)
        else $error("read data not zero outside a read answer");
    irq_masked_low_a: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq_out)
        else $error("interrupt high with every source masked");
    capture_latency_a: assert property (
        $rose(capture_pin_in) && mask_q == 4'h8 && !irq_out |-> cap_quiet ##0 cap_lands)
        else $error("capture landed outside its latency window");
    irq_clear_a: assert property (wr_in && addr_in == `OFS_STATUS && wdata_in[3]
        && mask_q == 4'h8 && !capture_pin_in |-> ##2 !irq_out)
        else $error("interrupt stayed high after its flag was cleared");
    irq_sticky_a: assert property ($fell(irq_out) |-> $past(wr_in) || $past(wr_in, 2))
        else $error("interrupt fell without a software write");
    crest_bound_a: assert property (
        func_q[1] && rd_in && addr_in == `OFS_CNT0 |=> rdata_out <= per_q + 16'h0001)
        else $error("counter0 went past one above the period");
    trough_bound_a: assert property (
        func_q[1] && rd_in && addr_in == `OFS_CNT1 |=> rdata_out <= per_q
        || rdata_out == `CNT_ALL_ONES)
        else $error("counter1 left its trough range");
    idle_phase_a: assert property (
        func_q == 4'h0 && $past(func_q) == 4'h0 && $past(func_q, 2) == 4'h0
        |-> pos_phase_out == '1 && neg_phase_out == '1)
        else $error("phase outputs active in timer mode");
endmodule

bind pwm_timer_top pwm_timer_monitor #(.WIDTH(WIDTH), .PHASES(PHASES)) i_pwm_timer_monitor (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .capture_pin_in(capture_pin_in), .rdata_out(rdata_out),
    .irq_out(irq_out), .pos_phase_out(pos_phase_out), .neg_phase_out(neg_phase_out));
`default_nettype wire

// [test/capture_source_model.sv]
// Far side of the timer: a capture signal source and the inverter gate drivers.
// Assumes the bench requests a pulse with a one-cycle fire strobe.
`timescale 1ns/10ps
`default_nettype none

module capture_source_model (
    input wire logic clock_in,
    input wire logic fire_in,
    input wire logic [2:0] pos_phase_in,
    input wire logic [2:0] neg_phase_in,
    output logic pin_out,
    output logic [2:0] gate_out
);
    logic [1:0] hold_q = 2'h0;
    always_ff @(posedge clock_in) begin
        if (fire_in) hold_q <= 2'h3;
        else if (hold_q != 2'h0) hold_q <= hold_q - 2'h1;
    end
    assign pin_out = (hold_q != 2'h0);
    // Gate stage latches each leg; a leg conducts only when its two inputs differ.
    always_ff @(posedge clock_in) begin
        gate_out <= pos_phase_in ^ neg_phase_in;
    end
endmodule
`default_nettype wire

// [test/dual_timer_complementary_pwm_control_tb.sv]
// Bench of the PWM timer: register port, capture interrupt and duty transfers.
// Assumes the design, the checker and the capture source model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_timer_regs.svh"

module dual_timer_complementary_pwm_control_tb;
    localparam logic [15:0] PER = 16'h0040;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic fire = 1'b0;
    logic capture_pin;
    logic [15:0] rdata_out;
    logic irq_out;
    logic [2:0] pos_phase_out;
    logic [2:0] neg_phase_out;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [15:0] rv;

    pwm_timer_top i_pwm_timer_top (.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .capture_pin_in(capture_pin),
        .rdata_out(rdata_out), .irq_out(irq_out), .pos_phase_out(pos_phase_out),
        .neg_phase_out(neg_phase_out));
    capture_source_model i_capture_source_model (.clock_in(clock_in), .fire_in(fire),
        .pos_phase_in(pos_phase_out), .neg_phase_in(neg_phase_out), .pin_out(capture_pin),
        .gate_out());

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, and a ceiling far above the few hundred cycles the tests need.
    initial begin
        forever #2.5 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Bus cycles: each strobe lasts one cycle and is lowered on the next edge.
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge clock_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1;
        rv = rdata_out;
        if (what != "") check(what, rv, exp);
    endtask

    task automatic do_reset();
        @(posedge clock_in);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        rst_n_in <= 1'b1;
    endtask

    // Bounded wait for the interrupt; running out counts as a mismatch.
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_out !== 1'b1 && n < 300) begin
            @(posedge clock_in);
            #1;
            n++;
        end
        check("irq wait", {15'h0000, irq_out}, 16'h0001);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, unmapped place, read-back and the reset-sync entry order.
    task automatic reg_access();
        rd_check(`OFS_PERIOD, `RST_PERIOD, "period reset");
        rd_check(`OFS_STATUS, 16'h0000, "status reset");
        wr_reg(8'h40, 16'hA5A5);
        rd_check(8'h40, 16'h0000, "unmapped");
        wr_reg(`OFS_BUF_U, 16'h1357);
        rd_check(`OFS_BUF_U, 16'h1357, "buffer u");
        wr_reg(`OFS_FUNC_CTRL, 16'h0000);
        wr_reg(`OFS_FUNC_CTRL, 16'h0001);
        rd_check(`OFS_FUNC_CTRL, 16'h0001, "function ctrl");
        wr_reg(`OFS_FUNC_CTRL, 16'h0000);
        $display("test reg_access done");
    endtask

    // Capture of a stopped counter, then the interrupt cleared, masked and unmasked.
    task automatic capture_irq();
        do_reset();
        wr_reg(`OFS_CNT0, 16'h1234);
        wr_reg(`OFS_IRQ_MASK, 16'h0008);
        @(posedge clock_in) fire <= 1'b1;
        @(posedge clock_in) fire <= 1'b0;
        wait_irq();
        rd_check(`OFS_CAPTURE, 16'h1234, "capture value");
        // idle cycle between write and read
        wr_reg(`OFS_STATUS, 16'h0008);
        rd_check(`OFS_STATUS, 16'h0000, "status cleared");
        wr_reg(`OFS_IRQ_MASK, 16'h0000);
        @(posedge clock_in) fire <= 1'b1;
        @(posedge clock_in) fire <= 1'b0;
        repeat (8) @(posedge clock_in);
        #1;
        check("irq masked", {15'h0000, irq_out}, 16'h0000);
        rd_check(`OFS_STATUS, 16'h0008, "status sticky");
        wr_reg(`OFS_IRQ_MASK, 16'h0008);
        repeat (2) @(posedge clock_in);
        #1;
        check("irq unmasked", {15'h0000, irq_out}, 16'h0001);
        $display("test capture_irq done");
    endtask

    // One complementary run: u normal, v at period, w zero; crest comes well before trough.
    task automatic run_comp(input logic [1:0] mode);
        logic [15:0] exp_u;
        exp_u = (mode == 2'b11) ? 16'h0005 : 16'h0008;
        do_reset();
        wr_reg(`OFS_BUF_MODE, 16'h0000);
        wr_reg(`OFS_PERIOD, PER);
        wr_reg(`OFS_GEN_U, 16'h0008);
        wr_reg(`OFS_GEN_V, 16'h0008);
        wr_reg(`OFS_GEN_W, 16'h0008);
        wr_reg(`OFS_BUF_U, 16'h0005);
        wr_reg(`OFS_BUF_V, PER);
        wr_reg(`OFS_BUF_W, 16'h0000);
        wr_reg(`OFS_BUF_MODE, 16'h0007);
        wr_reg(`OFS_CHAN_CTRL, 16'h0000);
        repeat (2) @(posedge clock_in);
        wr_reg(`OFS_FUNC_CTRL, 16'h0000);
        wr_reg(`OFS_FUNC_CTRL, {14'h0000, mode});
        wr_reg(`OFS_CNT0, PER - 16'h0003);
        wr_reg(`OFS_CNT1, PER);
        wr_reg(`OFS_IRQ_MASK, 16'h0001);
        // no direct duty writes from here
        wr_reg(`OFS_RUN_CTRL, 16'h0003);
        wait_irq();
        rd_check(`OFS_GEN_U, exp_u, "gen u at crest");
        rd_check(`OFS_GEN_V, 16'h0008, "gen v at crest");
        rd_check(`OFS_GEN_W, 16'h0000, "gen w at crest");
        rd_check(`OFS_CNT0, 16'h0000, "");
        rd_check(`OFS_CNT1, 16'h0000, "");
        wr_reg(`OFS_STATUS, 16'hFFFF);
        wr_reg(`OFS_IRQ_MASK, 16'h0002);
        wait_irq();
        rd_check(`OFS_GEN_U, 16'h0005, "gen u at trough");
        rd_check(`OFS_GEN_V, PER, "gen v at trough");
        rd_check(`OFS_STATUS, 16'h0000, "");
        check("overflow flag", rv & 16'h0004, 16'h0000);
        wr_reg(`OFS_RUN_CTRL, 16'h0000);
        wr_reg(`OFS_FUNC_CTRL, 16'h0000);
        repeat (3) @(posedge clock_in);
        #1;
        check("idle phases", {10'h000, pos_phase_out, neg_phase_out}, 16'h003F);
        $display("test run_comp mode %b done", mode);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        do_reset();
        reg_access();
        capture_irq();
        run_comp(2'b10);
        run_comp(2'b11);
        give_verdict();
    end
endmodule
`default_nettype wire
